// [axseq_step12.sv]
// Step-twelve sequencer configuration register and its apply logic.
// Assumes a plain register port with read data one cycle after strobe,
// and a sequencer that announces the step it executes on seq_step.
//
// Function
// - Register at 9Ch, resets to 000Ch
// - Bit 15 enables step twelve, read/write
// - Bits 14:13 gain: 1, 2, 4, 4
// - Bit 4 negative: ground or input seven
// - Codes 0-7 select external inputs 0-7
// - Internal codes pick negative input automatically
// - Code 8 temperature, code 9 ground short
// - Codes 10-15 test DAC and supply monitors
`timescale 1ns/1ps
`include "axseq_cfg.svh"
module axseq_step12 (
	input  wire logic                     clk_sys,
	input  wire logic                     nrst,
	input  wire logic [`AXSEQ_ADDR_W-1:0] reg_addr,
	input  wire logic [`AXSEQ_DATA_W-1:0] reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic      [`AXSEQ_DATA_W-1:0] reg_rdata,
	input  wire logic                     seq_valid,
	input  wire logic [3:0]               seq_step,
	output logic                          step_active,
	output logic                          step_skip,
	output axseq_pkg::axseq_gain_e        mux_gain,
	output axseq_pkg::axseq_neg_e         mux_neg,
	output axseq_pkg::axseq_src_t         mux_pos
);
	import axseq_pkg::*;

	// ****************************************
	// Register storage
	// ****************************************
	axseq_word_t cfg_r;
	logic        hit_wr;
	logic        hit_rd;
	logic        is_step12;
	axseq_if     f ();

	assign hit_wr = reg_wr && (reg_addr == `AXSEQ_STEP12_ADDR);
	assign hit_rd = reg_rd && (reg_addr == `AXSEQ_STEP12_ADDR);

	// Reserved bits 12:5 are never stored, so they always read zero
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cfg_r <= `AXSEQ_STEP12_RST;
		end else if (hit_wr) begin
			cfg_r <= reg_wdata & `AXSEQ_WMASK;
		end
	end

	// Read data valid only in the cycle after the strobe; others read 0
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= '0;
		end else if (hit_rd) begin
			reg_rdata <= cfg_r;
		end else begin
			reg_rdata <= '0;
		end
	end

	// ****************************************
	// Field decode
	// ****************************************
	assign f.step_enable_bit            = cfg_r[`AXSEQ_EN_BIT];
	assign f.step_gain_select           = cfg_r[`AXSEQ_GAIN_HI:`AXSEQ_GAIN_LO];
	assign f.step_negative_input_select = cfg_r[`AXSEQ_NEG_BIT];
	assign f.step_positive_input_select = cfg_r[`AXSEQ_POS_HI:`AXSEQ_POS_LO];

	axseq_dec u_dec (
		.f (f.dec)
	);

	// ****************************************
	// Apply to the converter mux
	// ****************************************
	assign is_step12 = seq_valid && (seq_step == `AXSEQ_STEP_NUM);

	// Mux stays parked on safe defaults outside step twelve, so a
	// register write mid-sequence cannot disturb other steps
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			step_active <= 1'b0;
			step_skip   <= 1'b0;
			mux_gain    <= AXSEQ_GAIN1;
			mux_neg     <= AXSEQ_NEG_AGND;
			mux_pos     <= '0;
		end else if (is_step12 && f.step_enable_bit) begin
			step_active <= 1'b1;
			step_skip   <= 1'b0;
			mux_gain    <= f.gain;
			mux_neg     <= f.neg;
			mux_pos     <= f.pos_onehot;
		end else begin
			step_active <= 1'b0;
			step_skip   <= is_step12;
			mux_gain    <= AXSEQ_GAIN1;
			mux_neg     <= AXSEQ_NEG_AGND;
			mux_pos     <= '0;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	property p_reset_value;
		@(posedge clk_sys) $rose(nrst) |-> cfg_r == `AXSEQ_STEP12_RST;
	endproperty
	a_reset_value: assert property (p_reset_value) else $error("bad reset value");

	property p_write_read;
		@(posedge clk_sys) disable iff (!nrst)
		hit_wr ##1 (hit_rd && !reg_wr) |=> reg_rdata == ($past(reg_wdata, 2) & `AXSEQ_WMASK);
	endproperty
	a_write_read: assert property (p_write_read) else $error("readback mismatch");

	property p_gain;
		@(posedge clk_sys) disable iff (!nrst)
		(is_step12 && f.step_enable_bit && f.step_gain_select[1]) |=> mux_gain == AXSEQ_GAIN4;
	endproperty
	a_gain: assert property (p_gain) else $error("gain not 4");

	property p_neg_ext;
		@(posedge clk_sys) disable iff (!nrst)
		(is_step12 && f.step_enable_bit && !f.step_positive_input_select[3])
		|=> mux_neg == ($past(f.step_negative_input_select) ? AXSEQ_NEG_IN7 : AXSEQ_NEG_AGND);
	endproperty
	a_neg_ext: assert property (p_neg_ext) else $error("negative select wrong");

	property p_pos_ext;
		@(posedge clk_sys) disable iff (!nrst)
		(is_step12 && f.step_enable_bit && f.step_positive_input_select == 4'h3)
		|=> mux_pos == 16'h0008;
	endproperty
	a_pos_ext: assert property (p_pos_ext) else $error("external input wrong");

	property p_neg_auto;
		@(posedge clk_sys) disable iff (!nrst)
		(is_step12 && f.step_enable_bit && f.step_positive_input_select[3])
		|=> mux_neg == AXSEQ_NEG_AUTO;
	endproperty
	a_neg_auto: assert property (p_neg_auto) else $error("auto negative missed");

	property p_short;
		@(posedge clk_sys) disable iff (!nrst)
		(is_step12 && f.step_enable_bit && f.step_positive_input_select == `AXSEQ_POS_SHORT)
		|=> mux_pos == 16'h0200 && mux_pos[7:0] == 8'h00;
	endproperty
	a_short: assert property (p_short) else $error("short not isolated");

	property p_drail;
		@(posedge clk_sys) disable iff (!nrst)
		(is_step12 && f.step_enable_bit && f.step_positive_input_select == `AXSEQ_POS_DRAIL103)
		|=> mux_pos == 16'h8000;
	endproperty
	a_drail: assert property (p_drail) else $error("digital rail monitor wrong");

	property p_skip;
		@(posedge clk_sys) disable iff (!nrst)
		(is_step12 && !f.step_enable_bit) |=> step_skip && !step_active && mux_pos == 16'h0000;
	endproperty
	a_skip: assert property (p_skip) else $error("disabled step not skipped");

	// Read data is the stored word as it stood at the strobe
	property p_rd_data;
		@(posedge clk_sys) disable iff (!nrst)
		hit_rd |=> reg_rdata == $past(cfg_r);
	endproperty
	a_rd_data: assert property (p_rd_data) else $error("read data not the stored word");

	// Read data stands one cycle only, so stale words never leak out
	property p_rd_idle;
		@(posedge clk_sys) disable iff (!nrst)
		!hit_rd |=> reg_rdata == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");

	// Reserved bits are never stored
	property p_reserved;
		@(posedge clk_sys) disable iff (!nrst)
		(cfg_r & ~`AXSEQ_WMASK) == 16'h0000;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits stored");

	// A write lands in the very next cycle
	property p_wr_store;
		@(posedge clk_sys) disable iff (!nrst)
		hit_wr |=> cfg_r == ($past(reg_wdata) & `AXSEQ_WMASK);
	endproperty
	a_wr_store: assert property (p_wr_store) else $error("write not stored");

	// Writes to other addresses leave the register alone
	property p_other_addr;
		@(posedge clk_sys) disable iff (!nrst)
		(reg_wr && reg_addr != `AXSEQ_STEP12_ADDR) |=> $stable(cfg_r);
	endproperty
	a_other_addr: assert property (p_other_addr) else $error("foreign write stored");

	property p_gain1;
		@(posedge clk_sys) disable iff (!nrst)
		(is_step12 && f.step_enable_bit && f.step_gain_select == 2'h0) |=> mux_gain == AXSEQ_GAIN1;
	endproperty
	a_gain1: assert property (p_gain1) else $error("gain not 1");

	property p_gain2;
		@(posedge clk_sys) disable iff (!nrst)
		(is_step12 && f.step_enable_bit && f.step_gain_select == 2'h1) |=> mux_gain == AXSEQ_GAIN2;
	endproperty
	a_gain2: assert property (p_gain2) else $error("gain not 2");

	property p_temp;
		@(posedge clk_sys) disable iff (!nrst)
		(is_step12 && f.step_enable_bit && f.step_positive_input_select == `AXSEQ_POS_TEMP)
		|=> mux_pos == 16'h0100;
	endproperty
	a_temp: assert property (p_temp) else $error("temperature source wrong");

	property p_tdac;
		@(posedge clk_sys) disable iff (!nrst)
		(is_step12 && f.step_enable_bit && f.step_positive_input_select == `AXSEQ_POS_TDAC)
		|=> mux_pos == 16'h0400;
	endproperty
	a_tdac: assert property (p_tdac) else $error("test source wrong");

	property p_active;
		@(posedge clk_sys) disable iff (!nrst)
		(is_step12 && f.step_enable_bit) |=> step_active && !step_skip;
	endproperty
	a_active: assert property (p_active) else $error("enabled step not run");

	// Other steps see the parked mux, whatever the register holds
	property p_idle;
		@(posedge clk_sys) disable iff (!nrst)
		!is_step12 |=> !step_active && !step_skip && mux_pos == 16'h0000
			&& mux_gain == AXSEQ_GAIN1 && mux_neg == AXSEQ_NEG_AGND;
	endproperty
	a_idle: assert property (p_idle) else $error("settings applied outside step");
endmodule // axseq_step12

// [axseq_cfg.svh]
// Constants for the step-twelve sequencer configuration register.
// Included by the design modules and the bench; definitions only.
`ifndef AXSEQ_CFG_SVH
`define AXSEQ_CFG_SVH
`define AXSEQ_ADDR_W       8
`define AXSEQ_DATA_W       16
`define AXSEQ_STEP12_ADDR  8'h9C
`define AXSEQ_STEP12_RST   16'h000C
`define AXSEQ_EN_BIT       15
`define AXSEQ_GAIN_HI      14
`define AXSEQ_GAIN_LO      13
`define AXSEQ_NEG_BIT      4
`define AXSEQ_POS_HI       3
`define AXSEQ_POS_LO       0
`define AXSEQ_WMASK        16'hE01F
`define AXSEQ_STEP_NUM     4'hC
`define AXSEQ_POS_INT_MIN  4'h8
`define AXSEQ_POS_TEMP     4'h8
`define AXSEQ_POS_SHORT    4'h9
`define AXSEQ_POS_TDAC     4'hA
`define AXSEQ_POS_AVDD4    4'hB
`define AXSEQ_POS_IOVDD4   4'hC
`define AXSEQ_POS_DVDD2    4'hD
`define AXSEQ_POS_ARAIL103 4'hE
`define AXSEQ_POS_DRAIL103 4'hF
`endif

// [axseq_pkg.sv]
// Types for the step-twelve sequencer configuration block.
// Assumes axseq_cfg.svh sits in the same folder.
package axseq_pkg;
	// Converter gain as applied by the sequencer
	typedef enum logic [2:0] {
		AXSEQ_GAIN1 = 3'h1,
		AXSEQ_GAIN2 = 3'h2,
		AXSEQ_GAIN4 = 3'h4
	} axseq_gain_e;
	// Negative input source, one-hot
	typedef enum logic [2:0] {
		AXSEQ_NEG_AGND = 3'h1,
		AXSEQ_NEG_IN7  = 3'h2,
		AXSEQ_NEG_AUTO = 3'h4
	} axseq_neg_e;
	typedef logic [15:0] axseq_word_t;
	typedef logic [15:0] axseq_src_t;
endpackage

// [axseq_if.sv]
// Interface carrying the decoded step settings between the register
// and the mux decoder. Single clock domain; no clocking block.
`timescale 1ns/1ps
interface axseq_if;
	import axseq_pkg::*;
	logic        step_enable_bit;
	logic [1:0]  step_gain_select;
	logic        step_negative_input_select;
	logic [3:0]  step_positive_input_select;
	axseq_gain_e gain;
	axseq_neg_e  neg;
	axseq_src_t  pos_onehot;
	modport regs (output step_enable_bit, output step_gain_select,
		output step_negative_input_select, output step_positive_input_select,
		input gain, input neg, input pos_onehot);
	modport dec  (input step_enable_bit, input step_gain_select,
		input step_negative_input_select, input step_positive_input_select,
		output gain, output neg, output pos_onehot);
endinterface // axseq_if

// [axseq_dec.sv]
// Combinational decode of the stored step fields into mux controls.
// Assumes fields arrive from the register through axseq_if.
`timescale 1ns/1ps
`include "axseq_cfg.svh"
module axseq_dec (
	axseq_if.dec f
);
	import axseq_pkg::*;
	// Gain codes 10b and 11b both give gain 4
	always_comb begin
		case (f.step_gain_select)
			2'h0:    f.gain = AXSEQ_GAIN1;
			2'h1:    f.gain = AXSEQ_GAIN2;
			default: f.gain = AXSEQ_GAIN4;
		endcase
	end
	// Internal sources pick their own negative input; the bit is ignored
	always_comb begin
		if (f.step_positive_input_select >= `AXSEQ_POS_INT_MIN) begin
			f.neg = AXSEQ_NEG_AUTO;
		end else if (f.step_negative_input_select) begin
			f.neg = AXSEQ_NEG_IN7;
		end else begin
			f.neg = AXSEQ_NEG_AGND;
		end
	end
	// One line per source: 0..7 external, 8 temp, 9 short, 10 test DAC, 11..15 monitors
	always_comb begin
		f.pos_onehot = 16'h0001 << f.step_positive_input_select;
	end
endmodule // axseq_dec

// [test_aux_adc_seq_step12_config.sv]
// Self-checking bench for the step-twelve sequencer configuration register.
// Assumes the design files, package and axseq_cfg.svh are compiled first.
`timescale 1ns/1ps
`include "axseq_cfg.svh"
module test_aux_adc_seq_step12_config;
	import axseq_pkg::*;
	logic        clk_sys;
	logic        nrst;
	logic [7:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;
	logic        seq_valid;
	logic [3:0]  seq_step;
	logic        step_active;
	logic        step_skip;
	axseq_gain_e mux_gain;
	axseq_neg_e  mux_neg;
	axseq_src_t  mux_pos;
	int          bad_count;
	int          n_compared;
	logic [2:0]  gain_tab [4];
	logic [2:0]  neg_x;

	axseq_step12 dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.seq_valid(seq_valid), .seq_step(seq_step), .step_active(step_active),
		.step_skip(step_skip), .mux_gain(mux_gain), .mux_neg(mux_neg), .mux_pos(mux_pos));

	// 25 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// ****************************************
	// Access tasks
	// ****************************************
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// Read data only stands in the cycle after the strobe, so sample there
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 check("reg_rdata", reg_rdata, exp);
	endtask
	// Write and read with no gap: the read must see the new word, then 0
	task automatic wr_rd(input logic [7:0] a, input logic [15:0] d, input logic [15:0] exp);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 check("reg_rdata", reg_rdata, exp);
		@(posedge clk_sys);
		#1 check("reg_rdata idle", reg_rdata, 16'h0000);
	endtask
	// One sequencer cycle, outputs seen one cycle later
	task automatic step(input logic [3:0] s, input logic act, input logic skp,
		input logic [2:0] g, input logic [2:0] ng, input logic [15:0] p);
		@(posedge clk_sys);
		seq_valid <= 1'b1;
		seq_step <= s;
		@(posedge clk_sys);
		seq_valid <= 1'b0;
		#1 check("step_active", {15'h0, step_active}, {15'h0, act});
		check("step_skip", {15'h0, step_skip}, {15'h0, skp});
		check("mux_gain", {13'h0, mux_gain}, {13'h0, g});
		check("mux_neg", {13'h0, mux_neg}, {13'h0, ng});
		check("mux_pos", mux_pos, p);
	endtask
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Watchdog, far beyond the 187 cycles the tests need
	initial begin
		repeat (5000) @(posedge clk_sys);
		bad_count++;
		report_and_stop();
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		gain_tab = '{3'h1, 3'h2, 3'h4, 3'h4};
		bad_count = 0;
		n_compared = 0;
		nrst = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		seq_valid = 1'b0;
		seq_step = 4'h0;
		repeat (8) @(posedge clk_sys);
		nrst <= 1'b1;
		rd(8'h9C, 16'h000C);
		step(4'hC, 1'b0, 1'b1, 3'h1, 3'h1, 16'h0000);
		$display("test reset done");
		// Reserved bits read zero; unmapped places neither store nor answer
		wr(8'h9C, 16'hFFFF);
		rd(8'h9C, 16'hE01F);
		wr(8'h9B, 16'h0000);
		rd(8'h9C, 16'hE01F);
		rd(8'h9D, 16'h0000);
		wr_rd(8'h9C, 16'hA5A5, 16'hA005);
		$display("test access done");
		for (int g = 0; g < 4; g++) begin
			wr(8'h9C, 16'h8001 | (16'(g) << 13));
			step(4'hC, 1'b1, 1'b0, gain_tab[g], 3'h1, 16'h0002);
		end
		$display("test gain done");
		// Every positive code with both negative selects
		for (int p = 0; p < 16; p++) begin
			for (int n = 0; n < 2; n++) begin
				neg_x = (p >= 8) ? 3'h4 : ((n == 1) ? 3'h2 : 3'h1);
				wr(8'h9C, 16'h8000 | (16'(n) << 4) | 16'(p));
				step(4'hC, 1'b1, 1'b0, 3'h1, neg_x, 16'h0001 << p);
			end
		end
		$display("test inputs done");
		// Cleared enable skips; other steps never apply these settings
		wr(8'h9C, 16'h4019);
		step(4'hC, 1'b0, 1'b1, 3'h1, 3'h1, 16'h0000);
		wr(8'h9C, 16'hC019);
		step(4'hB, 1'b0, 1'b0, 3'h1, 3'h1, 16'h0000);
		step(4'hC, 1'b1, 1'b0, 3'h4, 3'h4, 16'h0200);
		$display("test enable done");
		// A reset in mid-run brings back the reset word
		@(posedge clk_sys);
		nrst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		rd(8'h9C, 16'h000C);
		step(4'hC, 1'b0, 1'b1, 3'h1, 3'h1, 16'h0000);
		$display("test mid-run reset done");
		report_and_stop();
	end
endmodule // test_aux_adc_seq_step12_config
